// ===== src/fcr_regs.vh
// constants for the flash configuration register bank
`ifndef FCR_REGS_VH
`define FCR_REGS_VH

// ****************************************************************
// register defaults and masks
// ****************************************************************
`define FCR_NV_DEF      16'hFFFF
`define FCR_VOL_DEF     8'hFB
`define FCR_VOL_MASK    8'hFB
`define FCR_XIP_OFF     3'h7
`define FCR_DRV_DEF     3'h7

// ****************************************************************
// persistent_setup fields
// ****************************************************************
`define FCR_NV_DUMMY    15:12
`define FCR_NV_XIP      11:9
`define FCR_NV_DRIVE    8:6
`define FCR_NV_DTR      5
`define FCR_NV_HOLD     4
`define FCR_NV_QUAD     3
`define FCR_NV_DUAL     2
`define FCR_NV_SEG      1
`define FCR_NV_ADDR     0

// ****************************************************************
// runtime_setup fields
// ****************************************************************
`define FCR_VOL_DUMMY   7:4
`define FCR_VOL_XIP     3
`define FCR_VOL_WRAP    1:0

// ****************************************************************
// field codes
// ****************************************************************
`define FCR_DUMMY_ZERO  4'h0
`define FCR_DUMMY_MAX   4'hF
`define FCR_XIP_LAST    3'h4
`define FCR_WRAP_16     2'h0
`define FCR_WRAP_32     2'h1
`define FCR_WRAP_64     2'h2
`define FCR_MASK_16     6'h0F
`define FCR_MASK_32     6'h1F
`define FCR_MASK_64     6'h3F
`define FCR_MASK_NONE   6'h00

// ****************************************************************
// command codes and frame counts
// ****************************************************************
`define FCR_OP_RD_NV    8'hB5
`define FCR_OP_WR_NV    8'hB1
`define FCR_OP_RD_VOL   8'h85
`define FCR_OP_WR_VOL   8'h81
`define FCR_CNT_ZERO    5'h00
`define FCR_CNT_ONE     5'h01
`define FCR_CNT_OPLAST  5'h07
`define FCR_CNT_VOL     5'h08
`define FCR_CNT_NV      5'h10

`endif

// ===== src/fcr_nv_store.v
// nonvolatile word store with registered read data
`default_nettype none
`include "fcr_regs.vh"

module fcr_nv_store #(
	parameter        WIDTH     = 16,
	parameter [15:0] RESET_VAL = `FCR_NV_DEF
) (
	input  wire             clk,
	input  wire             porN,
	input  wire             we,
	input  wire [WIDTH-1:0] wd,
	output reg  [WIDTH-1:0] rd_q
);

	reg [WIDTH-1:0] data_q;

	// only power-on loads RESET_VAL into the store; plain reset leaves it alone
	always @(posedge clk or negedge porN) begin
		if (!porN) begin
			data_q <= RESET_VAL[WIDTH-1:0];
			rd_q   <= RESET_VAL[WIDTH-1:0];
		end else begin
			if (we) begin
				data_q <= wd;
			end
			rd_q <= data_q;
		end
	end

endmodule // fcr_nv_store

`default_nettype wire

// ===== src/fcr_config_bank.v
// configuration register bank of a serial flash, serial slave side
`default_nettype none
`include "fcr_regs.vh"

module fcr_config_bank #(
	parameter [3:0] DEFAULT_DUMMY = 4'h8
) (
	input  wire       clk,
	input  wire       nrst,
	input  wire       porN,
	input  wire       sclk,
	input  wire       csN,
	input  wire       mosi,
	output reg        miso_q,
	output reg        misoOe_q,
	output reg  [3:0] dummyCycles_q,
	output reg        xipActive_q,
	output reg  [2:0] xipMode_q,
	output reg  [2:0] driveCode_q,
	output reg        dtrOn_q,
	output reg        dataLineThreeHold_q,
	output reg        quadProto_q,
	output reg        dualProto_q,
	output reg        segHigh_q,
	output reg        fourByteAddr_q,
	output reg        extAddrIgnore_q,
	output reg  [5:0] wrapMask_q
);

	localparam [5:0] ST_LOAD  = 6'h01;
	localparam [5:0] ST_IDLE  = 6'h02;
	localparam [5:0] ST_CMD   = 6'h04;
	localparam [5:0] ST_WDATA = 6'h08;
	localparam [5:0] ST_RDATA = 6'h10;
	localparam [5:0] ST_SKIP  = 6'h20;

	// ************************************************************
	// decoders
	// ************************************************************
	function [3:0] dummyOf;
		input [3:0] code;
		input [3:0] fallback;
		begin
			if (code == `FCR_DUMMY_ZERO || code == `FCR_DUMMY_MAX) begin
				dummyOf = fallback;
			end else begin
				dummyOf = code;
			end
		end
	endfunction

	function [5:0] wrapMaskOf;
		input [1:0] code;
		begin
			case (code)
				`FCR_WRAP_16: wrapMaskOf = `FCR_MASK_16;
				`FCR_WRAP_32: wrapMaskOf = `FCR_MASK_32;
				`FCR_WRAP_64: wrapMaskOf = `FCR_MASK_64;
				default:      wrapMaskOf = `FCR_MASK_NONE;
			endcase
		end
	endfunction

	// ************************************************************
	// link synchronisers
	// ************************************************************
	reg [2:0] sclkSync_q;
	reg [1:0] csSync_q;
	reg [1:0] mosiSync_q;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclkSync_q <= 3'h0;
			csSync_q   <= 2'h3;
			mosiSync_q <= 2'h0;
		end else begin
			sclkSync_q <= {sclkSync_q[1:0], sclk};
			csSync_q   <= {csSync_q[0], csN};
			mosiSync_q <= {mosiSync_q[0], mosi};
		end
	end

	wire sclkRise = sclkSync_q[1] & ~sclkSync_q[2];
	wire sclkFall = ~sclkSync_q[1] & sclkSync_q[2];
	wire csHigh   = csSync_q[1];
	wire mosiBit  = mosiSync_q[1];

	// ************************************************************
	// persistent store
	// ************************************************************
	reg         nvWe_q;
	reg  [15:0] nvWd_q;
	wire [15:0] nvRd;

	fcr_nv_store #(
		.WIDTH     (16),
		.RESET_VAL (`FCR_NV_DEF)
	) u_store (
		.clk  (clk),
		.porN (porN),
		.we   (nvWe_q),
		.wd   (nvWd_q),
		.rd_q (nvRd)
	);

	// ************************************************************
	// command engine and internal configuration
	// ************************************************************
	reg  [5:0]  state_q;
	reg  [4:0]  cnt_q;
	reg  [15:0] sh_q;
	reg  [7:0]  op_q;
	reg  [15:0] out_q;
	reg  [7:0]  vol_q;
	wire [7:0]  opNext = {sh_q[6:0], mosiBit};
	wire [7:0]  volNew = sh_q[7:0] & `FCR_VOL_MASK;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q             <= ST_LOAD;
			cnt_q               <= `FCR_CNT_ZERO;
			sh_q                <= 16'h0000;
			op_q                <= 8'h00;
			out_q               <= 16'h0000;
			vol_q               <= `FCR_VOL_DEF;
			nvWe_q              <= 1'b0;
			nvWd_q              <= 16'h0000;
			miso_q              <= 1'b0;
			misoOe_q            <= 1'b0;
			dummyCycles_q       <= `FCR_DUMMY_MAX;
			xipActive_q         <= 1'b0;
			xipMode_q           <= `FCR_XIP_OFF;
			driveCode_q         <= `FCR_DRV_DEF;
			dtrOn_q             <= 1'b0;
			dataLineThreeHold_q <= 1'b1;
			quadProto_q         <= 1'b0;
			dualProto_q         <= 1'b0;
			segHigh_q           <= 1'b0;
			fourByteAddr_q      <= 1'b0;
			extAddrIgnore_q     <= 1'b0;
			wrapMask_q          <= `FCR_MASK_NONE;
		end else begin
			nvWe_q <= 1'b0;
			case (state_q)
				ST_LOAD: begin
					state_q <= ST_IDLE;
					dummyCycles_q <= dummyOf(nvRd[`FCR_NV_DUMMY],
						`FCR_DUMMY_MAX);
					xipMode_q   <= nvRd[`FCR_NV_XIP];
					xipActive_q <= (nvRd[`FCR_NV_XIP] <= `FCR_XIP_LAST);
					driveCode_q <= nvRd[`FCR_NV_DRIVE];
					dtrOn_q <= ~nvRd[`FCR_NV_DTR];
					dataLineThreeHold_q <= nvRd[`FCR_NV_HOLD];
					quadProto_q <= ~nvRd[`FCR_NV_QUAD];
					dualProto_q <= nvRd[`FCR_NV_QUAD] & ~nvRd[`FCR_NV_DUAL];
					segHigh_q <= ~nvRd[`FCR_NV_SEG];
					fourByteAddr_q <= ~nvRd[`FCR_NV_ADDR];
					extAddrIgnore_q <= ~nvRd[`FCR_NV_ADDR];
					wrapMask_q <= wrapMaskOf(vol_q[`FCR_VOL_WRAP]);
				end
				ST_IDLE: begin
					if (!csHigh) begin
						cnt_q   <= `FCR_CNT_ZERO;
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (csHigh) begin
						state_q <= ST_IDLE;
					end else if (sclkRise) begin
						sh_q  <= {sh_q[14:0], mosiBit};
						cnt_q <= cnt_q + `FCR_CNT_ONE;
						if (cnt_q == `FCR_CNT_OPLAST) begin
							op_q  <= opNext;
							cnt_q <= `FCR_CNT_ZERO;
							if (opNext == `FCR_OP_RD_NV) begin
								out_q   <= nvRd;
								state_q <= ST_RDATA;
							end else if (opNext == `FCR_OP_RD_VOL) begin
								out_q   <= {vol_q, vol_q};
								state_q <= ST_RDATA;
							end else if (opNext == `FCR_OP_WR_NV ||
								opNext == `FCR_OP_WR_VOL) begin
								state_q <= ST_WDATA;
							end else begin
								state_q <= ST_SKIP;
							end
						end
					end
				end
				ST_WDATA: begin
					if (csHigh) begin
						state_q <= ST_IDLE;
						// persistent word acts only at next reset
						if (op_q == `FCR_OP_WR_NV &&
							cnt_q == `FCR_CNT_NV) begin
							nvWe_q <= 1'b1;
							nvWd_q <= sh_q;
						end
						if (op_q == `FCR_OP_WR_VOL &&
							cnt_q == `FCR_CNT_VOL) begin
							vol_q <= volNew;
							dummyCycles_q <= dummyOf(volNew[`FCR_VOL_DUMMY],
								DEFAULT_DUMMY);
							xipActive_q <= ~volNew[`FCR_VOL_XIP];
							wrapMask_q <= wrapMaskOf(volNew[`FCR_VOL_WRAP]);
						end
					end else if (sclkRise && cnt_q != `FCR_CNT_NV) begin
						sh_q  <= {sh_q[14:0], mosiBit};
						cnt_q <= cnt_q + `FCR_CNT_ONE;
					end
				end
				ST_RDATA: begin
					if (csHigh) begin
						misoOe_q <= 1'b0;
						state_q  <= ST_IDLE;
					end else if (sclkFall) begin
						// rotation repeats the word while clocks continue
						misoOe_q <= 1'b1;
						miso_q   <= out_q[15];
						out_q    <= {out_q[14:0], out_q[15]};
					end
				end
				ST_SKIP: begin
					if (csHigh) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // fcr_config_bank

`default_nettype wire

// ===== verif/fcr_config_bank_sva.sv
// assertions on the configuration bank ports
`default_nettype none
module fcr_config_bank_sva (
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       csN,
	input wire logic       misoOe_q,
	input wire logic [3:0] dummyCycles_q,
	input wire logic       xipActive_q,
	input wire logic       quadProto_q,
	input wire logic       dualProto_q,
	input wire logic       fourByteAddr_q,
	input wire logic       extAddrIgnore_q,
	input wire logic [5:0] wrapMask_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// ********************************
	// port relations
	// ********************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_ext; extAddrIgnore_q == fourByteAddr_q; endproperty
	a_ext: assert property (p_ext)
		else $error("address mode flags differ");
	property p_proto; !(quadProto_q && dualProto_q); endproperty
	a_proto: assert property (p_proto)
		else $error("quad and dual both active");
	property p_wrap;
		wrapMask_q inside {6'h00, 6'h0F, 6'h1F, 6'h3F};
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("illegal wrap mask");
	property p_dummy; dummyCycles_q != 4'h0; endproperty
	a_dummy: assert property (p_dummy)
		else $error("zero dummy count");
	// config only moves while deselected (reload or commit)
	property p_cfg;
		$changed({dummyCycles_q, xipActive_q, wrapMask_q}) |-> $past(csN);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("config changed inside a frame");
	property p_oeoff; $rose(csN) |-> ##[1:5] !misoOe_q; endproperty
	a_oeoff: assert property (p_oeoff)
		else $error("output enable held after deselect");
	property p_oelag; misoOe_q |-> !$past(csN, 4); endproperty
	a_oelag: assert property (p_oelag)
		else $error("output enable outside a frame");
	property p_oerise; $rose(misoOe_q) |-> !csN && !$past(csN, 8); endproperty
	a_oerise: assert property (p_oerise)
		else $error("output enable before opcode done");
	c_read: cover property ($rose(misoOe_q));
	c_wrap: cover property ($changed(wrapMask_q));
	c_quad: cover property (quadProto_q);
endmodule // fcr_config_bank_sva
bind fcr_config_bank fcr_config_bank_sva fcr_config_bank_sva_i (
	.clk(clk), .nrst(nrst), .csN(csN), .misoOe_q(misoOe_q),
	.dummyCycles_q(dummyCycles_q), .xipActive_q(xipActive_q),
	.quadProto_q(quadProto_q), .dualProto_q(dualProto_q),
	.fourByteAddr_q(fourByteAddr_q), .extAddrIgnore_q(extAddrIgnore_q),
	.wrapMask_q(wrapMask_q));
`default_nettype wire

// ===== verif/fcr_host.sv
// serial host model issuing register frames
`default_nettype none
module fcr_host (
	input  wire logic clk,
	input  wire logic miso,
	input  wire logic misoOe,
	output var  logic sclk,
	output var  logic csN,
	output var  logic mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rd;
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
		rd = 16'h0000;
	end
	// no fast reads
	// mode 0, sclk idles low; opcode then n bits msb first
	task automatic xfer(input logic [7:0] op, input logic [15:0] d,
		input int n);
		logic [23:0] sh;
		sh = {op, d << (16 - n)};
		@(posedge clk);
		#1 csN = 1'b0;
		for (int i = 0; i < 8 + n; i++) begin
			mosi = sh[23 - i];
			repeat (4) @(posedge clk);
			#1 sclk = 1'b1;
			// released line reads as inverse of last bit
			if (i >= 8)
				rd = {rd[14:0], misoOe ? miso : ~rd[0]};
			repeat (4) @(posedge clk);
			#1 sclk = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 csN = 1'b1;
		mosi = ~mosi;
		repeat (8) @(posedge clk);
	endtask
endmodule // fcr_host
`default_nettype wire

// ===== verif/tb.sv
// testbench for the configuration register bank
`default_nettype none
`include "fcr_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] DUMMY_DEF = 4'h8;
	logic        clk, nrst, porN;
	wire logic   miso, misoOe, sclk, csN, mosi;
	wire logic [23:0] cfg;
	logic [23:0] expQ[$];
	logic [23:0] obs, en;
	logic [15:0] w;
	logic [7:0]  v;
	int          failures, compares, seed, i;
	event        obsEv;
	fcr_config_bank #(.DEFAULT_DUMMY(DUMMY_DEF)) fcr_config_bank_i (
		.clk(clk), .nrst(nrst), .porN(porN), .sclk(sclk), .csN(csN),
		.mosi(mosi), .miso_q(miso), .misoOe_q(misoOe),
		.dummyCycles_q(cfg[23:20]), .xipActive_q(cfg[19]),
		.xipMode_q(cfg[18:16]), .driveCode_q(cfg[15:13]),
		.dtrOn_q(cfg[12]), .dataLineThreeHold_q(cfg[11]),
		.quadProto_q(cfg[10]), .dualProto_q(cfg[9]), .segHigh_q(cfg[8]),
		.fourByteAddr_q(cfg[7]), .extAddrIgnore_q(cfg[6]),
		.wrapMask_q(cfg[5:0]));
	fcr_host fcr_host_i (.clk(clk), .miso(miso), .misoOe(misoOe),
		.sclk(sclk), .csN(csN), .mosi(mosi));
	always #50 clk = ~clk;
	function automatic logic [23:0] expNv(input logic [15:0] x);
		logic [3:0] dc;
		dc = (x[15:12] == 4'h0) ? 4'hF : x[15:12];
		return {dc, x[11:9] <= 3'h4, x[11:9], x[8:6], ~x[5], x[4], ~x[3],
			~x[2] & x[3], ~x[1], ~x[0], ~x[0], 6'h00};
	endfunction
	function automatic logic [23:0] expVol(input logic [23:0] e,
		input logic [7:0] x);
		logic [3:0] dc;
		dc = (x[7:4] == 4'h0 || x[7:4] == 4'hF) ? DUMMY_DEF : x[7:4];
		e[23:19] = {dc, ~x[3]};
		e[5:0] = (x[1:0] == 2'h3) ? 6'h00 : (6'h10 << x[1:0]) - 6'h01;
		return e;
	endfunction
	task automatic check(input logic [23:0] s, input logic [23:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h expected %h",
				$time, s, e);
		end
	endtask
	task automatic note(input logic [23:0] e, input logic [23:0] s);
		expQ.push_back(e);
		obs = s;
		->obsEv;
		#1;
	endtask
	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// nrst alone keeps the persistent word
	task automatic rst_pulse;
		@(posedge clk);
		#1 nrst = 1'b0;
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (6) @(posedge clk);
	endtask
	always @(obsEv) check(obs, expQ.pop_front());
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		test_done();
	end
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		porN = 1'b0;
		failures = 0;
		compares = 0;
		seed = 137;
		repeat (12) @(posedge clk);
		#1 nrst = 1'b1;
		porN = 1'b1;
		repeat (6) @(posedge clk);
		note(expNv(`FCR_NV_DEF), cfg);
		fcr_host_i.xfer(`FCR_OP_RD_NV, 16'h0000, 16);
		note({8'h00, `FCR_NV_DEF}, {8'h00, fcr_host_i.rd});
		fcr_host_i.xfer(`FCR_OP_RD_VOL, 16'h0000, 8);
		note({16'h0000, `FCR_VOL_DEF}, {16'h0000, fcr_host_i.rd[7:0]});
		$display("test defaults done");
		// every xip, drive and protocol code in turn
		for (i = 0; i < 8; i++) begin
			w = 16'($random(seed));
			w[11:0] = {i[2:0], i[2:0], ~i[2], i[0], i[1:0], i[1], i[0]};
			if (i == 0)
				w[15:12] = 4'h0;
			fcr_host_i.xfer(`FCR_OP_WR_NV, w, 16);
			fcr_host_i.xfer(`FCR_OP_RD_NV, 16'h0000, 16);
			note({8'h00, w}, {8'h00, fcr_host_i.rd});
			rst_pulse();
			note(expNv(w), cfg);
			note(expNv(w), cfg);
		end
		$display("test persistent done");
		en = expNv(w);
		for (i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			v[1:0] = i[1:0];
			if (i >= 4)
				v[7:4] = (i == 4) ? 4'h0 : 4'hF;
			fcr_host_i.xfer(`FCR_OP_WR_VOL, {8'h00, v}, 8);
			en = expVol(en, v);
			note(en, cfg);
			fcr_host_i.xfer(`FCR_OP_RD_VOL, 16'h0000, 8);
			note({16'h0000, v & `FCR_VOL_MASK},
				{16'h0000, fcr_host_i.rd[7:0]});
		end
		// nine data bits: write dropped
		fcr_host_i.xfer(`FCR_OP_WR_VOL, 16'h0155, 9);
		note(en, cfg);
		// unknown opcode: frame ignored, config untouched
		fcr_host_i.xfer(8'h5A, 16'h0000, 8);
		note(en, cfg);
		rst_pulse();
		note(expNv(w), cfg);
		$display("test runtime done");
		test_done();
	end
endmodule // tb
`default_nettype wire
